// ===== apb_user_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Controlling program seen as an APB master.
// ------------------------------------------------
module apb_user_model (
    input  wire logic        clk_sys,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic [11:0]      paddr = 12'h000,
    output logic [31:0]      pwdata = 32'h0
);
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [32:0] ex;
    logic [31:0] mk;

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic err);
        exp_q.push_back({err, e});
        msk_q.push_back(m);
        xfer(1'b0, a, 32'h0);
    endtask

    // The answer is judged at the edge that completes the access.
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            ex = exp_q.pop_front();
            mk = msk_q.pop_front();
            testbench.n_tests++;
            if ({pslverr, prdata & mk} !== {ex[32], ex[31:0] & mk}) begin
                testbench.failures++;
                $display("BAD read %h exp %h seen %h", paddr, ex,
                         {pslverr, prdata});
            end
        end
    end
endmodule
`default_nettype wire

// ===== counter_ctrl_defines.svh
`ifndef COUNTER_CTRL_DEFINES_SVH
`define COUNTER_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define OFS_CONTROL     12'h000
`define OFS_STATUS      12'h004
`define OFS_FAULT       12'h008
`define OFS_LOAD_VALUE  12'h00c
`define OFS_SNAPSHOT    12'h010
`define OFS_COUNT       12'h014
`define OFS_COMPARE     12'h018

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_EVENT_ACK    0
`define CTL_FAULT_ACK    1
`define CTL_SW_GATE      2
`define CTL_SNAP_ARM     3
`define CTL_PRESET_ARM   4
`define CTL_PRESET_UP    5
`define CTL_PRESET_DOWN  6
`define CTL_LOAD_STROBE  7
`define CTL_APPLY_DIR    8
`define CTL_REQ_DIR_DOWN 9
`define CTL_SET_OUT0     10
`define CTL_SET_OUT1     11
`define CTL_OVR0         12
`define CTL_OVR1         13
`define CTL_MODE0_LSB    14
`define CTL_MODE1_LSB    16
`define CTL_SINGLE_PULSE 18
`define CTL_FAULT_NEWACK 19
`define CTL_VIRT_OUT0    20
`define CTL_OUT1_ROUTED  21
`define CTL_RESET        32'h0000_0000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define ST_CMP0     0
`define ST_CMP1     1
`define ST_ZERO     2
`define ST_HIGH     3
`define ST_LOW      4
`define ST_IN0      5
`define ST_IN1      6
`define ST_IN2      7
`define ST_FAULT    8
`define ST_SNAP_OK  9
`define ST_PRESET   10
`define ST_GATE     11
`define ST_DOWN     12
`define ST_OUT0     13
`define ST_OUT1     14
`define ST_VIRT0    15

`endif

// ===== counter_ctrl_pkg.sv
package counter_ctrl_pkg;

    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_PROGRAM,
        OUT_SET_UNTIL_CMP,
        OUT_COMPARE
    } out_mode_type;

    typedef struct packed {
        logic cmp0;
        logic cmp1;
        logic zero;
        logic high;
        logic low;
    } event_type;

    typedef struct packed {
        logic       valid;
        logic [15:0] code;
    } fault_type;

    typedef enum {
        FLT_CLEAR,
        FLT_REPORTED
    } fault_state_type;

endpackage

// ===== counter_event_output_control.sv
// Function
// [R01] Event acknowledge edge clears five sticky flags.
// [R02] Software holds acknowledge until flags clear.
// [R03] Three input levels readable as status.
// [R04] Set bits act only in enabled modes.
// [R05] Program mode or override follows set bit.
// [R06] Set-until-compare: rise sets, compare/fall clears.
// [R07] Virtual output toggles on edges, compare clears.
// [R08] Virtual output internal; output one needs routing.
// [R09] Error sets flag and shows fault code.
// [R10] Acknowledge clears flag only without pending error.
// [R11] No new error until previous acknowledged.
// [R12] Old version edge ack, new level ack.
// [R13] Program direction only for single pulse.
// [R14] Apply direction adopts requested up or down.
// [R15] Software gate edges; internal gate needs both.
// [R16] Arm captures next edge; fall cancels, clears.
// [R17] Snapshot value held until next capture.
// [R18] Preset flag cleared on arm fall; directions.
// [R19] Load strobe rise transfers value at once.
// [R20] Preset needs arm, direction enable, edge.
// [R21] Capture sets snapshot valid.
// [R22] Edges found against registered previous samples.
// [R23] Sticky flags hold until acknowledged, reset zero.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "counter_ctrl_defines.svh"

module counter_event_output_control #(
    parameter int CW = 32
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [2:0]    din,
    input  wire logic          hw_gate,
    input  wire logic          enc_dir_down,
    input  wire logic          count_pulse,
    input  wire logic          capture_edge,
    input  wire logic          preset_edge,
    input  wire logic [CW-1:0] preset_value,
    input  wire logic          high_limit_hit,
    input  wire logic          low_limit_hit,
    input  wire logic          core_error,
    input  wire logic [15:0]   core_error_code,
    output logic               output_0,
    output logic               output_1,
    output logic               internal_gate,
    output logic               count_down
);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [31:0]   ctrl_ff;
    logic [CW-1:0] load_count_value_ff;
    logic [CW-1:0] compare_value_ff;
    logic [CW-1:0] count_ff;
    logic [CW-1:0] snapshot_value_ff;
    logic [31:0]   status;
    logic          wr_en;
    logic          rd_en;
    logic          addr_ok;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign addr_ok = (paddr == `OFS_CONTROL) || (paddr == `OFS_STATUS) ||
                     (paddr == `OFS_FAULT) || (paddr == `OFS_LOAD_VALUE) ||
                     (paddr == `OFS_SNAPSHOT) || (paddr == `OFS_COUNT) ||
                     (paddr == `OFS_COMPARE);
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_ff             <= `CTL_RESET;
            load_count_value_ff <= '0;
            compare_value_ff    <= '0;
        end else if (wr_en) begin
            case (paddr)
                `OFS_CONTROL:    ctrl_ff <= pwdata;
                `OFS_LOAD_VALUE: load_count_value_ff <= pwdata[CW-1:0];
                `OFS_COMPARE:    compare_value_ff <= pwdata[CW-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    // The previous sample of every control bit, so each edge is one pulse.
    logic [31:0] ctrl_prev_ff;
    logic [31:0] ctrl_rise;
    logic [31:0] ctrl_fall;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_prev_ff <= `CTL_RESET;
        end else begin
            ctrl_prev_ff <= ctrl_ff; // [R22]
        end
    end
    assign ctrl_rise = ctrl_ff & ~ctrl_prev_ff;
    assign ctrl_fall = ~ctrl_ff & ctrl_prev_ff;

    // ------------------------------------------------------------------
    // Gate and direction
    // ------------------------------------------------------------------
    logic sw_gate_ff;
    logic dir_prog_down_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sw_gate_ff <= 1'b0;
        end else if (ctrl_rise[`CTL_SW_GATE]) begin
            sw_gate_ff <= 1'b1; // [R15]
        end else if (ctrl_fall[`CTL_SW_GATE]) begin
            sw_gate_ff <= 1'b0; // [R15]
        end
    end
    assign internal_gate = sw_gate_ff && hw_gate; // [R15]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_prog_down_ff <= 1'b0;
        end else if (ctrl_ff[`CTL_APPLY_DIR] && ctrl_ff[`CTL_SINGLE_PULSE]) begin
            dir_prog_down_ff <= ctrl_ff[`CTL_REQ_DIR_DOWN]; // [R13] [R14]
        end
    end
    assign count_down = ctrl_ff[`CTL_SINGLE_PULSE] ? dir_prog_down_ff
                                                   : enc_dir_down; // [R13]

    // ------------------------------------------------------------------
    // Counter, preset and snapshot
    // ------------------------------------------------------------------
    logic preset_ok;
    logic preset_occurred_ff;
    logic snap_pending_ff;
    logic snapshot_valid_ff;
    logic do_capture;

    assign preset_ok = ctrl_ff[`CTL_PRESET_ARM] && preset_edge &&
                       (count_down ? ctrl_ff[`CTL_PRESET_DOWN]
                                   : ctrl_ff[`CTL_PRESET_UP]); // [R20]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else if (ctrl_rise[`CTL_LOAD_STROBE]) begin
            count_ff <= load_count_value_ff; // [R19]
        end else if (preset_ok) begin
            count_ff <= preset_value; // [R20]
        end else if (count_pulse && internal_gate) begin
            count_ff <= count_down ? count_ff - 1'b1 : count_ff + 1'b1;
        end
    end

    // A preset in the clearing cycle wins so no synchronisation goes unseen.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            preset_occurred_ff <= 1'b0;
        end else if (preset_ok) begin
            preset_occurred_ff <= 1'b1; // [R20]
        end else if (ctrl_fall[`CTL_PRESET_ARM] || ctrl_fall[`CTL_PRESET_UP] ||
                     ctrl_fall[`CTL_PRESET_DOWN]) begin
            preset_occurred_ff <= 1'b0; // [R18]
        end
    end

    assign do_capture = snap_pending_ff && ctrl_ff[`CTL_SNAP_ARM] &&
                        capture_edge; // [R16]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            snap_pending_ff <= 1'b0;
        end else if (ctrl_fall[`CTL_SNAP_ARM] || do_capture) begin
            snap_pending_ff <= 1'b0; // [R16]
        end else if (ctrl_rise[`CTL_SNAP_ARM]) begin
            snap_pending_ff <= 1'b1; // [R16]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            snapshot_valid_ff <= 1'b0;
        end else if (ctrl_fall[`CTL_SNAP_ARM]) begin
            snapshot_valid_ff <= 1'b0; // [R16]
        end else if (do_capture) begin
            snapshot_valid_ff <= 1'b1; // [R21]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            snapshot_value_ff <= '0;
        end else if (do_capture) begin
            snapshot_value_ff <= count_ff; // [R17]
        end
    end

    // ------------------------------------------------------------------
    // Sticky events
    // ------------------------------------------------------------------
    counter_ctrl_pkg::event_type events_ff;
    counter_ctrl_pkg::event_type ev_set;
    logic [CW-1:0] prev_count_ff;
    logic          cmp_hit;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_count_ff <= '0;
        end else begin
            prev_count_ff <= count_ff;
        end
    end
    assign cmp_hit = (count_ff == compare_value_ff) &&
                     (prev_count_ff != count_ff);
    assign ev_set.cmp0 = cmp_hit;
    assign ev_set.cmp1 = cmp_hit;
    assign ev_set.zero = (count_ff == '0) && (prev_count_ff != '0);
    assign ev_set.high = high_limit_hit;
    assign ev_set.low  = low_limit_hit;

    // An event in the acknowledge cycle survives so nothing is lost.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            events_ff <= '0; // [R23]
        end else if (ctrl_rise[`CTL_EVENT_ACK]) begin
            events_ff <= ev_set; // [R01]
        end else begin
            events_ff <= events_ff | ev_set; // [R23]
        end
    end

    // ------------------------------------------------------------------
    // Digital outputs
    // ------------------------------------------------------------------
    counter_ctrl_pkg::out_mode_type mode0;
    counter_ctrl_pkg::out_mode_type mode1;
    logic [1:0] out_ff;
    logic [1:0] nxt_out;

    assign mode0 = counter_ctrl_pkg::out_mode_type'(
                       ctrl_ff[`CTL_MODE0_LSB +: 2]);
    assign mode1 = counter_ctrl_pkg::out_mode_type'(
                       ctrl_ff[`CTL_MODE1_LSB +: 2]);

    for (genvar i = 0; i < 2; i++) begin : g_out
        counter_ctrl_pkg::out_mode_type m;
        logic set_bit;
        logic set_rise;
        logic set_fall;
        logic ovr;
        logic virt;
        assign m        = (i == 0) ? mode0 : mode1;
        assign set_bit  = ctrl_ff[`CTL_SET_OUT0 + i];
        assign set_rise = ctrl_rise[`CTL_SET_OUT0 + i];
        assign set_fall = ctrl_fall[`CTL_SET_OUT0 + i];
        assign ovr      = ctrl_ff[`CTL_OVR0 + i];
        assign virt     = (i == 0) && ctrl_ff[`CTL_VIRT_OUT0];
        logic nxt_bit;
        always_comb begin
            nxt_bit = out_ff[i];
            if (ovr || m == counter_ctrl_pkg::OUT_PROGRAM) begin
                nxt_bit = set_bit; // [R05]
            end else if (m == counter_ctrl_pkg::OUT_SET_UNTIL_CMP) begin
                if (cmp_hit) begin
                    nxt_bit = 1'b0; // [R06] [R07]
                end else if (virt && (set_rise || set_fall)) begin
                    nxt_bit = ~out_ff[i]; // [R07]
                end else if (!virt && set_rise) begin
                    nxt_bit = 1'b1; // [R06]
                end else if (!virt && set_fall) begin
                    nxt_bit = 1'b0; // [R06]
                end
            end else if (m == counter_ctrl_pkg::OUT_COMPARE) begin
                nxt_bit = cmp_hit ? 1'b1 : out_ff[i];
            end else begin
                nxt_bit = 1'b0; // [R04]
            end
        end
        assign nxt_out[i] = nxt_bit;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_ff <= 2'b00;
        end else begin
            out_ff <= nxt_out;
        end
    end

    // Output zero has no pin in the virtual variant, where output one needs a route.
    assign output_0 = out_ff[0] && !ctrl_ff[`CTL_VIRT_OUT0]; // [R08]
    assign output_1 = out_ff[1] &&
                      (!ctrl_ff[`CTL_VIRT_OUT0] ||
                       ctrl_ff[`CTL_OUT1_ROUTED]); // [R08]

    // ------------------------------------------------------------------
    // Error reporting
    // ------------------------------------------------------------------
    counter_ctrl_pkg::fault_state_type fstate_ff;
    counter_ctrl_pkg::fault_type       fault_ff;
    logic fault_ack;
    logic err_pending;

    assign fault_ack = ctrl_ff[`CTL_FAULT_NEWACK] ? ctrl_ff[`CTL_FAULT_ACK]
                                                  : ctrl_rise[`CTL_FAULT_ACK];
    assign err_pending = core_error || pslverr;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fstate_ff <= counter_ctrl_pkg::FLT_CLEAR;
            fault_ff  <= '0;
        end else begin
            case (fstate_ff)
                counter_ctrl_pkg::FLT_CLEAR: begin
                    if (err_pending) begin
                        fstate_ff      <= counter_ctrl_pkg::FLT_REPORTED;
                        fault_ff.valid <= 1'b1; // [R09]
                        fault_ff.code  <= pslverr ? 16'h0001
                                                     : core_error_code; // [R09]
                    end
                end
                counter_ctrl_pkg::FLT_REPORTED: begin
                    if (fault_ack && !err_pending) begin // [R12] [R11]
                        fstate_ff <= counter_ctrl_pkg::FLT_CLEAR;
                        fault_ff  <= '0; // [R10]
                    end
                end
                default: fstate_ff <= counter_ctrl_pkg::FLT_CLEAR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        status = '0;
        status[`ST_CMP0]    = events_ff.cmp0;
        status[`ST_CMP1]    = events_ff.cmp1;
        status[`ST_ZERO]    = events_ff.zero;
        status[`ST_HIGH]    = events_ff.high;
        status[`ST_LOW]     = events_ff.low;
        status[`ST_IN0]     = din[0]; // [R03]
        status[`ST_IN1]     = din[1]; // [R03]
        status[`ST_IN2]     = din[2]; // [R03]
        status[`ST_FAULT]   = fault_ff.valid;
        status[`ST_SNAP_OK] = snapshot_valid_ff;
        status[`ST_PRESET]  = preset_occurred_ff;
        status[`ST_GATE]    = internal_gate;
        status[`ST_DOWN]    = count_down;
        status[`ST_OUT0]    = output_0;
        status[`ST_OUT1]    = output_1;
        status[`ST_VIRT0]   = out_ff[0];
    end

    always_comb begin
        prdata = '0;
        if (rd_en) begin
            case (paddr)
                `OFS_CONTROL:    prdata = ctrl_ff;
                `OFS_STATUS:     prdata = status;
                `OFS_FAULT:      prdata = {16'h0000, fault_ff.code};
                `OFS_LOAD_VALUE: prdata = 32'(load_count_value_ff);
                `OFS_SNAPSHOT:   prdata = 32'(snapshot_value_ff);
                `OFS_COUNT:      prdata = 32'(count_ff);
                `OFS_COMPARE:    prdata = 32'(compare_value_ff);
                default:         prdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    ack_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_rise[`CTL_EVENT_ACK] && ev_set == '0 |=> events_ff == '0) // [R01]
        else $error("event flags not cleared by acknowledge");
    sticky_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        events_ff.high && !ctrl_rise[`CTL_EVENT_ACK] |=> events_ff.high) // [R23]
        else $error("sticky flag dropped");
    sw_gate_open_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_rise[`CTL_SW_GATE] |=> sw_gate_ff) // [R15]
        else $error("software gate not opened by rising edge");
    override_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_ff[`CTL_OVR0] |=> out_ff[0] == $past(ctrl_ff[`CTL_SET_OUT0])) // [R05]
        else $error("override output not following set bit");
    capture_valid_a: assert property (@(posedge clk_sys) disable iff (rst)
        do_capture |=> snapshot_valid_ff && snapshot_value_ff == $past(count_ff)) // [R21]
        else $error("capture not recorded");
    snap_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !do_capture |=> $stable(snapshot_value_ff)) // [R17]
        else $error("snapshot changed without capture");
    load_count_a: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_rise[`CTL_LOAD_STROBE] |=> count_ff == $past(load_count_value_ff)) // [R19]
        else $error("load value not transferred");
    fault_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        fault_ff.valid && !fault_ack |=> fault_ff.valid && $stable(fault_ff.code)) // [R11]
        else $error("fault changed before acknowledge");

endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "counter_ctrl_defines.svh"
// ------------------------------------------------
// Self-checking bench.
// ------------------------------------------------
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  din = 3'h0;
    logic        hw_gate = 1'b0;
    logic        enc_dir_down = 1'b0;
    logic [4:0]  pl = 5'h0;
    logic [31:0] preset_value = 32'h0;
    logic        core_error = 1'b0;
    logic [15:0] core_error_code = 16'h0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, pv;
    logic        output_0, output_1, internal_gate, count_down;
    int          failures = 0;
    int          n_tests = 0;

    counter_event_output_control counter_event_output_control_inst (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .din(din), .hw_gate(hw_gate), .enc_dir_down(enc_dir_down),
        .count_pulse(pl[0]), .capture_edge(pl[1]),
        .preset_edge(pl[2]), .preset_value(preset_value),
        .high_limit_hit(pl[3]), .low_limit_hit(pl[4]),
        .core_error(core_error), .core_error_code(core_error_code),
        .output_0(output_0), .output_1(output_1),
        .internal_gate(internal_gate), .count_down(count_down));

    apb_user_model apb_user_model_inst (
        .clk_sys(clk_sys), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        apb_user_model_inst.rd(a, e, m, 1'b0);
    endtask

    // Edge detection lags the write, so effects are awaited here.
    task automatic wc(input logic [31:0] c);
        apb_user_model_inst.xfer(1'b1, `OFS_CONTROL, c);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic pulse(input int k);
        pl[k] <= 1'b1;
        @(posedge clk_sys);
        pl[k] <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic chk(input string s, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %b seen %b", s, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100us;
        failures++;
        tally_and_finish();
    end

    initial begin
        v = $urandom(32'h78cb6943);
        din <= v[2:0];
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`OFS_CONTROL, 32'h0, 32'hffffffff);
        rd(`OFS_STATUS, {24'h0, din, 5'h0}, 32'hffff);
        pulse(3);
        pulse(4);
        rd(`OFS_STATUS, 32'h18, 32'h1f);
        wc(32'h1);
        rd(`OFS_STATUS, 32'h0, 32'h1f);
        wc(32'h0);
        $display("test events done");
        for (int m = 0; m < 4; m++) begin
            wc((m << 14) | 32'h400);
            chk("out0 set", m == 1 || m == 2, output_0);
            wc(m << 14);
            chk("out0 clr", 1'b0, output_0);
        end
        wc(32'h1400);
        chk("out0 ovr", 1'b1, output_0);
        wc(32'h110800);
        chk("out1 unrouted", 1'b0, output_1);
        wc(32'h310800);
        chk("out1 routed", 1'b1, output_1);
        wc(32'h108000);
        wc(32'h108400);
        rd(`OFS_STATUS, 32'h8000, 32'ha000);
        chk("out0 virt", 1'b0, output_0);
        wc(32'h108000);
        rd(`OFS_STATUS, 32'h0, 32'h8000);
        wc(32'h0);
        $display("test outputs done");
        v = $urandom();
        apb_user_model_inst.xfer(1'b1, `OFS_LOAD_VALUE, v);
        wc(32'h80);
        rd(`OFS_COUNT, v, 32'hffffffff);
        hw_gate <= 1'b1;
        wc(32'h84);
        chk("gate open", 1'b1, internal_gate);
        apb_user_model_inst.xfer(1'b1, `OFS_COMPARE, v + 32'h2);
        for (int i = 0; i < 3; i++) pulse(0);
        rd(`OFS_COUNT, v + 32'h3, 32'hffffffff);
        rd(`OFS_STATUS, 32'h3, 32'h3);
        hw_gate <= 1'b0;
        @(posedge clk_sys);
        chk("gate hw", 1'b0, internal_gate);
        pulse(0);
        rd(`OFS_COUNT, v + 32'h3, 32'hffffffff);
        wc(32'h0);
        $display("test gate done");
        enc_dir_down <= 1'b1;
        wc(32'h300);
        chk("dir enc", 1'b1, count_down);
        enc_dir_down <= 1'b0;
        wc(32'h40000);
        wc(32'h40300);
        chk("dir down", 1'b1, count_down);
        wc(32'h40000);
        wc(32'h40100);
        chk("dir up", 1'b0, count_down);
        wc(32'h0);
        $display("test direction done");
        wc(32'h8);
        pulse(1);
        rd(`OFS_SNAPSHOT, v + 32'h3, 32'hffffffff);
        rd(`OFS_STATUS, 32'h200, 32'h200);
        wc(32'h0);
        rd(`OFS_STATUS, 32'h0, 32'h200);
        pulse(1);
        rd(`OFS_STATUS, 32'h0, 32'h200);
        rd(`OFS_SNAPSHOT, v + 32'h3, 32'hffffffff);
        $display("test capture done");
        pv = $urandom();
        preset_value <= pv;
        wc(32'h50);
        pulse(2);
        rd(`OFS_COUNT, v + 32'h3, 32'hffffffff);
        wc(32'h30);
        pulse(2);
        rd(`OFS_COUNT, pv, 32'hffffffff);
        rd(`OFS_STATUS, 32'h400, 32'h400);
        wc(32'h20);
        rd(`OFS_STATUS, 32'h0, 32'h400);
        wc(32'h0);
        $display("test preset done");
        apb_user_model_inst.rd(12'h100, 32'h0, 32'hffffffff, 1'b1);
        rd(`OFS_FAULT, 32'h1, 32'hffff);
        core_error <= 1'b1;
        core_error_code <= 16'h8000 | 16'($urandom());
        rd(`OFS_FAULT, 32'h1, 32'hffff);
        wc(32'h2);
        rd(`OFS_STATUS, 32'h100, 32'h100);
        core_error <= 1'b0;
        rd(`OFS_STATUS, 32'h100, 32'h100);
        wc(32'h0);
        wc(32'h2);
        rd(`OFS_STATUS, 32'h0, 32'h100);
        core_error <= 1'b1;
        wc(32'h80000);
        rd(`OFS_FAULT, {16'h0, core_error_code}, 32'hffff);
        core_error <= 1'b0;
        wc(32'h80002);
        rd(`OFS_STATUS, 32'h0, 32'h100);
        $display("test fault done");
        repeat (3) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule
`default_nettype wire
